// ===== design/dtc_top.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "dtc_map.svh"
module dtc_top (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic [9:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire dtc_pkg::dtc_word_t avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output dtc_pkg::dtc_word_t     avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              unit0_count_pin_i,
  output logic                   unit0_count_pin_o,
  output logic                   unit0_count_pin_oe_o,
  input  wire logic              unit1_count_pin_i,
  output logic                   unit1_count_pin_o,
  output logic                   unit1_count_pin_oe_o,
  input  wire logic              ext_irq_pin_zero_i,
  input  wire logic              ext_irq_pin_one_i,
  input  wire logic              low_speed_crystal_clock_i,
  input  wire logic              isr0_enter_i,
  input  wire logic              isr1_enter_i,
  output logic                   unit0_overflow_flag_o,
  output logic                   unit1_overflow_flag_o
);
  import dtc_pkg::*;

  function automatic dtc_step_t dtc_step(dtc_mode_t m, dtc_byte_t hi, dtc_byte_t lo);
    dtc_step_t s;
    s.hi  = hi;
    s.lo  = lo;
    s.ovf = 1'b0;
    unique case (m)
      DTC_M13: begin
        // upper three low-byte bits are left alone
        {s.ovf, s.hi, s.lo[4:0]} = {1'b0, hi, lo[4:0]} + 14'h0001;
      end
      DTC_M16: begin
        {s.ovf, s.hi, s.lo} = {1'b0, hi, lo} + 17'h00001;
      end
      DTC_M8R: begin
        {s.ovf, s.lo} = {1'b0, lo} + 9'h001;
        if (s.ovf) begin
          s.lo = hi;
        end
      end
      DTC_MSPLIT: begin
        {s.ovf, s.lo} = {1'b0, lo} + 9'h001;
      end
    endcase
    return s;
  endfunction

  // registers
  logic [1:0] run_reg;
  logic [1:0] flag_reg;
  dtc_byte_t  timer_mode_reg;
  dtc_byte_t  timer_clock_select_reg;
  dtc_byte_t  aux_reg;
  dtc_byte_t  p3m_reg;
  dtc_byte_t  lo_reg [2];
  dtc_byte_t  hi_reg [2];
  logic [1:0] tog_reg;
  logic       wait_reg;
  dtc_word_t  rdata_reg;
  logic [3:0] div_reg;

  // bus decode
  logic       bus_req;
  logic       bus_wr;
  logic [7:0] bus_idx;
  dtc_byte_t  wdata;
  dtc_byte_t  rd_mux;
  logic       wr_timer_control;
  logic [1:0] wr_lo;
  logic [1:0] wr_hi;

  // synchronisers and count sources
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] irq_s1;
  logic [1:0] irq_s2;
  logic       lxt_s1;
  logic       lxt_s2;
  logic       lxt_s3;
  logic       lxt_rise;
  logic       div_tick;
  logic [1:0] pin_fall;
  logic [1:0] tmr_tick;
  logic [1:0] src_tick;
  logic [1:0] gate_ok;
  logic [1:0] cnt_en;
  logic [1:0] ovf;
  logic [1:0] isr_clr;
  logic [1:0] flag_set;
  dtc_ucfg_t  cfg [2];
  dtc_step_t  step [2];
  logic       split0;
  logic       hi0_en;
  logic       hi0_ovf;

  assign bus_req  = avs_read_i | avs_write_i;
  assign bus_idx  = avs_address_i[9:2];
  assign wdata    = avs_writedata_i[7:0];
  // writes land on the edge where waitrequest is seen low
  assign bus_wr   = avs_write_i & ~wait_reg & avs_byteenable_i[0];
  assign wr_timer_control  = bus_wr && (bus_idx == `DTC_IDX_TIMER_CONTROL);
  assign wr_lo[0] = bus_wr && (bus_idx == `DTC_IDX_UNIT0_COUNT_LOW);
  assign wr_lo[1] = bus_wr && (bus_idx == `DTC_IDX_UNIT1_COUNT_LOW);
  assign wr_hi[0] = bus_wr && (bus_idx == `DTC_IDX_UNIT0_COUNT_HIGH);
  assign wr_hi[1] = bus_wr && (bus_idx == `DTC_IDX_UNIT1_COUNT_HIGH);

  always_comb begin
    unique case (bus_idx)
      `DTC_IDX_TIMER_CONTROL:      rd_mux = {flag_reg[1], run_reg[1], flag_reg[0], run_reg[0], 4'h0};
      `DTC_IDX_TIMER_MODE:         rd_mux = timer_mode_reg;
      `DTC_IDX_UNIT0_COUNT_LOW:    rd_mux = lo_reg[0];
      `DTC_IDX_UNIT1_COUNT_LOW:    rd_mux = lo_reg[1];
      `DTC_IDX_UNIT0_COUNT_HIGH:   rd_mux = hi_reg[0];
      `DTC_IDX_UNIT1_COUNT_HIGH:   rd_mux = hi_reg[1];
      `DTC_IDX_TIMER_CLOCK_SELECT: rd_mux = timer_clock_select_reg;
      `DTC_IDX_AUXILIARY_ONE:      rd_mux = aux_reg;
      `DTC_IDX_PORT3_MODE_ONE:     rd_mux = p3m_reg;
      default:                     rd_mux = `DTC_RST_ZERO;
    endcase
  end

  // one wait cycle per access, so readdata is ready when wait drops
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_i && wait_reg) begin
      rdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  // configuration registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      timer_mode_reg  <= `DTC_RST_ZERO;
      timer_clock_select_reg <= `DTC_RST_ZERO;
      aux_reg   <= `DTC_RST_ZERO;
      p3m_reg   <= `DTC_RST_PORT3_MODE;
    end else if (bus_wr) begin
      if (bus_idx == `DTC_IDX_TIMER_MODE) begin
        timer_mode_reg <= wdata;
      end
      // unimplemented bits of timer_clock_select and auxiliary_one are never stored, so they always read zero
      if (bus_idx == `DTC_IDX_TIMER_CLOCK_SELECT) begin
        timer_clock_select_reg <= wdata & `DTC_CK_MASK;
      end
      if (bus_idx == `DTC_IDX_AUXILIARY_ONE) begin
        aux_reg <= wdata & `DTC_AUX_MASK;
      end
      if (bus_idx == `DTC_IDX_PORT3_MODE_ONE) begin
        p3m_reg <= wdata;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      run_reg <= 2'b00;
    end else if (wr_timer_control) begin
      for (int k = 0; k < 2; k++) begin
        run_reg[k] <= wdata[`DTC_TIMER_CONTROL_RUN_LSB + `DTC_TIMER_CONTROL_UNIT_STEP * k];
      end
    end
  end

  // prescaler shared by both units
  assign div_tick = (div_reg == `DTC_DIV_LAST);
  always_ff @(posedge core_clk_i) begin
    if (rst_i || div_tick) begin
      div_reg <= `DTC_RST_DIV;
    end else begin
      div_reg <= div_reg + `DTC_DIV_STEP;
    end
  end

  // crystal is slow against core_clk, so a rising edge is one count
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lxt_s1 <= 1'b0;
      lxt_s2 <= 1'b0;
      lxt_s3 <= 1'b0;
    end else begin
      lxt_s1 <= low_speed_crystal_clock_i;
      lxt_s2 <= lxt_s1;
      lxt_s3 <= lxt_s2;
    end
  end
  assign lxt_rise = lxt_s2 & ~lxt_s3;

  assign split0  = (cfg[0].mode == DTC_MSPLIT);
  // in split mode the high byte of unit 0 borrows unit 1's run bit
  assign hi0_en  = split0 && run_reg[1] && tmr_tick[0];
  assign hi0_ovf = hi0_en && (hi_reg[0] == `DTC_BYTE_MAX);
  assign isr_clr = {isr1_enter_i, isr0_enter_i};
  assign flag_set[0] = ovf[0];
  assign flag_set[1] = split0 ? hi0_ovf : ovf[1];

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_unit
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          pin_s1[i] <= 1'b1;
          pin_s2[i] <= 1'b1;
          pin_s3[i] <= 1'b1;
          irq_s1[i] <= 1'b0;
          irq_s2[i] <= 1'b0;
        end else begin
          pin_s1[i] <= i ? unit1_count_pin_i : unit0_count_pin_i;
          pin_s2[i] <= pin_s1[i];
          pin_s3[i] <= pin_s2[i];
          irq_s1[i] <= i ? ext_irq_pin_one_i : ext_irq_pin_zero_i;
          irq_s2[i] <= irq_s1[i];
        end
      end

      assign cfg[i]      = timer_mode_reg[`DTC_TIMER_MODE_UNIT_W * i +: `DTC_TIMER_MODE_UNIT_W];
      // history stage costs a cycle but compares two settled samples
      assign pin_fall[i] = pin_s3[i] & ~pin_s2[i];
      assign tmr_tick[i] = timer_clock_select_reg[`DTC_CK_UNDIV_LSB + i] | div_tick;
      // slow crystal first, then counter pin, then internal timer clock
      assign src_tick[i] = aux_reg[`DTC_AUX_SLOW_LSB + i] ? lxt_rise :
                           (cfg[i].ct ? pin_fall[i] : tmr_tick[i]);
      assign gate_ok[i]  = ~cfg[i].gate | irq_s2[i];
      assign step[i]     = dtc_step(cfg[i].mode, hi_reg[i], lo_reg[i]);
      assign ovf[i]      = cnt_en[i] & step[i].ovf;

      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          lo_reg[i] <= `DTC_RST_ZERO;
          hi_reg[i] <= `DTC_RST_ZERO;
        end else begin
          if (cnt_en[i]) begin
            lo_reg[i] <= step[i].lo;
            hi_reg[i] <= step[i].hi;
          end
          if (i == 0 && hi0_en) begin
            hi_reg[i] <= hi_reg[i] + 8'h01;
          end
          // a software write wins over a count in the same cycle
          if (wr_lo[i]) begin
            lo_reg[i] <= wdata;
          end
          if (wr_hi[i]) begin
            hi_reg[i] <= wdata;
          end
        end
      end

      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          flag_reg[i] <= 1'b0;
        end else if (flag_set[i]) begin
          flag_reg[i] <= 1'b1;
        end else if (wr_timer_control) begin
          flag_reg[i] <= wdata[`DTC_TIMER_CONTROL_FLAG_LSB + `DTC_TIMER_CONTROL_UNIT_STEP * i];
        end else if (isr_clr[i]) begin
          flag_reg[i] <= 1'b0;
        end
      end

      // toggle idles at one while disabled, so it starts high when enabled
      always_ff @(posedge core_clk_i) begin
        if (rst_i || !p3m_reg[`DTC_P3_TOE_LSB + i]) begin
          tog_reg[i] <= 1'b1;
        end else if (ovf[i]) begin
          tog_reg[i] <= ~tog_reg[i];
        end
      end
    end
  endgenerate

  assign cnt_en[0] = run_reg[0] && gate_ok[0] && src_tick[0];
  // unit 1 loses its run bit to unit 0 while unit 0 is split
  assign cnt_en[1] = (split0 || run_reg[1]) && gate_ok[1] && src_tick[1]
                     && (cfg[1].mode != DTC_MSPLIT);

  assign avs_readdata_o        = rdata_reg;
  assign avs_waitrequest_o     = wait_reg;
  assign unit0_count_pin_o     = tog_reg[0];
  assign unit1_count_pin_o     = tog_reg[1];
  assign unit0_count_pin_oe_o  = p3m_reg[`DTC_P3_TOE_LSB];
  assign unit1_count_pin_oe_o  = p3m_reg[`DTC_P3_TOE_LSB + 1];
  assign unit0_overflow_flag_o = flag_reg[0];
  assign unit1_overflow_flag_o = flag_reg[1];

  a_div_twelve: assert property (@(posedge core_clk_i) disable iff (rst_i)
    div_tick |-> ##1 !div_tick ##11 div_tick)
    else $error("prescaler tick spacing is not twelve");

  a_flag0_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ovf[0] |=> flag_reg[0])
    else $error("unit0 overflow did not set its flag");

  a_split_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    hi0_ovf |=> flag_reg[1])
    else $error("split high byte overflow did not set unit1 flag");

  a_flag_isr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (isr1_enter_i && !flag_set[1] && !wr_timer_control) |=> !flag_reg[1])
    else $error("unit1 flag not cleared on isr entry");

  a_run0_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!run_reg[0] && !split0 && !bus_wr) |=> ($stable(lo_reg[0]) && $stable(hi_reg[0])))
    else $error("unit0 count moved while halted");

  a_unit1_freeze: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg[1].mode == DTC_MSPLIT && !bus_wr) [*2] |-> ($stable(lo_reg[1]) && $stable(hi_reg[1])))
    else $error("unit1 counted in mode 3");

  a_gate0_block: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg[0].gate && !irq_s2[0] && !split0 && !bus_wr) |=> $stable(lo_reg[0]))
    else $error("unit0 counted with gate low");

  a_reload_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ovf[0] && cfg[0].mode == DTC_M8R && !bus_wr) |=> (lo_reg[0] == $past(hi_reg[0])))
    else $error("reload did not copy high byte");

  a_m13_roll: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cnt_en[0] && cfg[0].mode == DTC_M13 && {hi_reg[0], lo_reg[0][4:0]} == `DTC_M13_MAX && !bus_wr)
    |=> (flag_reg[0] && hi_reg[0] == 8'h00 && lo_reg[0][4:0] == 5'h00))
    else $error("13-bit roll did not flag");

  a_pin_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pin_fall[0] |-> ($past(unit0_count_pin_i, 3) && !$past(unit0_count_pin_i, 2)))
    else $error("pin fall without high then low");

  a_toggle_flip: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ovf[1] && p3m_reg[`DTC_P3_TOE_LSB + 1] && !bus_wr) |=> (unit1_count_pin_o != $past(unit1_count_pin_o)))
    else $error("unit1 pin did not toggle on overflow");

  a_wait_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (bus_req && wait_reg) |=> !wait_reg ##1 wait_reg)
    else $error("waitrequest did not drop for exactly one cycle");

endmodule

// ===== design/dtc_map.svh
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// register indices, byte address is four times the index
`define DTC_IDX_TIMER_CONTROL      8'h88
`define DTC_IDX_TIMER_MODE         8'h89
`define DTC_IDX_UNIT0_COUNT_LOW    8'h8a
`define DTC_IDX_UNIT1_COUNT_LOW    8'h8b
`define DTC_IDX_UNIT0_COUNT_HIGH   8'h8c
`define DTC_IDX_UNIT1_COUNT_HIGH   8'h8d
`define DTC_IDX_TIMER_CLOCK_SELECT 8'h8e
`define DTC_IDX_AUXILIARY_ONE      8'ha2
`define DTC_IDX_PORT3_MODE_ONE     8'hac

// reset values
`define DTC_RST_ZERO        8'h00
`define DTC_RST_PORT3_MODE  8'h3f
`define DTC_RST_DIV         4'h0

// timer_control fields, unit 1 sits two bits above unit 0
`define DTC_TIMER_CONTROL_RUN_LSB    4
`define DTC_TIMER_CONTROL_FLAG_LSB   5
`define DTC_TIMER_CONTROL_UNIT_STEP  2
// timer_mode: one nibble per unit
`define DTC_TIMER_MODE_UNIT_W     4
// timer_clock_select, auxiliary_one, port3_mode_one
`define DTC_CK_UNDIV_LSB    3
`define DTC_AUX_SLOW_LSB    4
`define DTC_P3_TOE_LSB      6
// stored bits of timer_clock_select and auxiliary_one
`define DTC_CK_MASK         8'h18
`define DTC_AUX_MASK        8'h30

// divide-by-12 prescaler, last count value
`define DTC_DIV_LAST        4'hb
`define DTC_DIV_STEP        4'h1
// count limits
`define DTC_BYTE_MAX        8'hff
`define DTC_M13_MAX         13'h1fff

`endif

// ===== design/dtc_pkg.sv
package dtc_pkg;

  typedef logic [31:0] dtc_word_t;
  typedef logic [7:0]  dtc_byte_t;

  typedef enum logic [1:0] {
    DTC_M13    = 2'b00,
    DTC_M16    = 2'b01,
    DTC_M8R    = 2'b10,
    DTC_MSPLIT = 2'b11
  } dtc_mode_t;

  // one nibble of timer_mode
  typedef struct packed {
    logic      gate;
    logic      ct;
    dtc_mode_t mode;
  } dtc_ucfg_t;

  // result of one count step
  typedef struct packed {
    dtc_byte_t hi;
    dtc_byte_t lo;
    logic      ovf;
  } dtc_step_t;

endpackage

// ===== sim/dtc_pins.sv
`timescale 1ns/100ps
module dtc_pins (
  input  wire logic       clk_i,
  input  wire logic [1:0] ext_i,
  input  wire logic [1:0] pin_i,
  input  wire logic [1:0] pin_oe_i,
  output logic      [1:0] pin_o,
  output logic            xtal_o
);
  int n = 0;
  initial xtal_o = 1'b0;
  // a driving device wins over the outside source
  assign pin_o = (pin_oe_i & pin_i) | (~pin_oe_i & ext_i);
  // slow crystal, period 32 core cycles, so its rate stays apart from the divider
  always @(posedge clk_i) begin
    n <= n + 1;
    xtal_o <= n[4];
  end
endmodule

// ===== sim/test_dtc_top.sv
`timescale 1ns/100ps
module test_dtc_top;
  import dtc_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [9:0] adr = '0;
  logic       rd = 1'b0;
  logic       wr = 1'b0;
  dtc_word_t  wd = '0;
  dtc_word_t  rdat;
  logic       wt;
  logic [1:0] ext = 2'b11;
  logic [1:0] irq = 2'b00;
  logic [1:0] isr = 2'b00;
  logic [1:0] cp, po, poe, fl, pl;
  logic       xtal;
  logic [7:0] lf = 8'h1e;
  logic [7:0] ri [10] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'ha2, 8'hac, 8'hf0};
  logic [7:0] re [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00};
  int         err_count = 0;
  int         checks = 0;
  int         cyc = 0;
  int         tg = 0;
  int         tu = 0;

  always #2.5 clk = ~clk;

  dtc_top i_dtc_top (.core_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'h1), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .unit0_count_pin_i(cp[0]), .unit0_count_pin_o(po[0]),
    .unit0_count_pin_oe_o(poe[0]), .unit1_count_pin_i(cp[1]), .unit1_count_pin_o(po[1]),
    .unit1_count_pin_oe_o(poe[1]), .ext_irq_pin_zero_i(irq[0]), .ext_irq_pin_one_i(irq[1]),
    .low_speed_crystal_clock_i(xtal), .isr0_enter_i(isr[0]), .isr1_enter_i(isr[1]),
    .unit0_overflow_flag_o(fl[0]), .unit1_overflow_flag_o(fl[1]));

  dtc_pins i_dtc_pins (.clk_i(clk), .ext_i(ext), .pin_i(po), .pin_oe_i(poe), .pin_o(cp), .xtal_o(xtal));

  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, generous against the roughly 3.3k cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pl <= po;
    if (po[tu] !== pl[tu]) tg <= tg + 1;
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      err_count++;
    end
  endtask

  task automatic chkr(input logic [15:0] g, input int lo, input int hi);
    checks++;
    if ((^g === 1'bx) || g < lo || g > hi) begin
      $display("[ERR] %0t got %h exp %h..%h", $time, g, lo, hi);
      err_count++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {i, 2'b00};
    wd <= {24'h0, d};
    rd <= ~w;
    wr <= w;
    do @(posedge clk); while (wt !== 1'b0 && ++n < 50);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk(16'h0, 16'h1);
  endtask

  task automatic wr_r(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask

  task automatic pulse(input int u, input int k);
    repeat (k) begin
      @(posedge clk);
      ext[u] <= 1'b0;
      repeat (3) @(posedge clk);
      ext[u] <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask

  function automatic logic [7:0] nx(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // reference count step per mode
  function automatic void ms(input int u, input int m, inout int h, inout int l, inout int f);
    int c;
    c = 0;
    if (m == 0) begin
      c = (h * 32 + l % 32 + 1) % 8192;
      f = f | (c == 0);
      h = c / 32;
      l = l / 32 * 32 + c % 32;
    end else if (m == 1) begin
      c = (h * 256 + l + 1) % 65536;
      f = f | (c == 0);
      h = c / 256;
      l = c % 256;
    end else if (m == 2 || u == 0) begin
      l = (l + 1) % 256;
      f = f | (l == 0);
      if (l == 0 && m == 2) l = h;
    end
  endfunction

  initial begin
    logic [7:0] q, h, l;
    int eh, el, ef, n, e;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wr_r(8'hf0, 8'h55);
    for (int k = 0; k < 10; k++) begin
      bus(1'b0, ri[k], 8'h00, q);
      chk(q, re[k]);
    end
    chk(poe, 2'b00);
    chk(po, 2'b11);
    for (int u = 0; u < 2; u++)
      for (int m = 0; m < 4; m++)
        for (int g = 0; g < 2; g++) begin
          lf = nx(lf);
          h = (m == 2) ? 8'hf3 : 8'hff;
          l = lf | 8'hf8;
          n = 1 + lf[6:4];
          wr_r(8'h88, 8'h00);
          wr_r(8'h89, {g[0], 1'b1, m[1:0], 4'h0} >> (4 - 4 * u));
          wr_r(8'h8a + u, l);
          wr_r(8'h8c + u, h);
          irq <= 2'b00;
          wr_r(8'h88, 8'h10 << (2 * u));
          if (g == 1) pulse(u, 2);
          irq[u] <= 1'b1;
          repeat (4) @(posedge clk);
          pulse(u, n);
          repeat (6) @(posedge clk);
          eh = h;
          el = l;
          ef = 0;
          repeat (n) ms(u, m, eh, el, ef);
          bus(1'b0, 8'h88, 8'h00, q);
          chk(q[5 + 2 * u], 16'(ef));
          bus(1'b0, 8'h8a + u, 8'h00, q);
          chk(q, 16'(el));
          bus(1'b0, 8'h8c + u, 8'h00, q);
          chk(q, 16'(eh));
        end
    for (int u = 0; u < 2; u++)
      for (int s = 0; s < 3; s++) begin
        wr_r(8'h88, 8'h00);
        wr_r(8'h89, 8'h01 << (4 * u));
        wr_r(8'h8a + u, 8'h00);
        wr_r(8'h8c + u, 8'h00);
        wr_r(8'h8e, (s == 1) ? 8'h08 << u : 8'h00);
        wr_r(8'ha2, (s == 2) ? 8'h10 << u : 8'h00);
        wr_r(8'h88, 8'h10 << (2 * u));
        repeat (240) @(posedge clk);
        wr_r(8'h88, 8'h00);
        bus(1'b0, 8'h8a + u, 8'h00, l);
        bus(1'b0, 8'h8c + u, 8'h00, h);
        e = (s == 0) ? 20 : (s == 1) ? 240 : 7;
        chkr({h, l}, e - 2, e + e / 8 + 4);
        repeat (20) @(posedge clk);
        bus(1'b0, 8'h8a + u, 8'h00, q);
        chk(q, l);
      end
    wr_r(8'ha2, 8'h00);
    for (int u = 0; u < 2; u++) begin
      wr_r(8'h8e, 8'h08 << u);
      wr_r(8'h89, 8'h02 << (4 * u));
      wr_r(8'h8c + u, 8'hf0);
      wr_r(8'h8a + u, 8'hf0);
      wr_r(8'h88, 8'h00);
      wr_r(8'hac, 8'h40 << u);
      @(negedge clk);
      chk(poe[u], 16'h1);
      chk(po[u], 16'h1);
      tu = u;
      tg = 0;
      wr_r(8'h88, 8'h10 << (2 * u));
      repeat (160) @(posedge clk);
      bus(1'b0, 8'h88, 8'h00, q);
      wr_r(8'h88, 8'h00);
      chk(q[5 + 2 * u], 16'h1);
      chkr(16'(tg), 9, 12);
      wr_r(8'h88, 8'h20 << (2 * u));
      @(negedge clk);
      chk(fl[u], 16'h1);
      @(posedge clk);
      isr[u] <= 1'b1;
      @(posedge clk);
      isr[u] <= 1'b0;
      @(negedge clk);
      chk(fl[u], 16'h0);
      wr_r(8'hac, 8'h00);
      @(negedge clk);
      chk(poe[u], 16'h0);
      chk(po[u], 16'h1);
    end
    // unit0 split: high byte runs on unit1's run bit, unit1 frozen in mode 3
    wr_r(8'h88, 8'h00);
    wr_r(8'h8e, 8'h08);
    wr_r(8'h89, 8'h33);
    wr_r(8'h8a, 8'h10);
    wr_r(8'h8c, 8'hf0);
    wr_r(8'h88, 8'h40);
    repeat (20) @(posedge clk);
    bus(1'b0, 8'h88, 8'h00, q);
    wr_r(8'h88, 8'h00);
    chk(q, 16'hc0);
    bus(1'b0, 8'h8c, 8'h00, h);
    chkr(16'(h), 8, 12);
    bus(1'b0, 8'h8a, 8'h00, l);
    chk(l, 16'h10);
    summarize();
  end
endmodule
